// File: sim/pin_source.sv
// Far-side model: capture signal source and external count clock pin
`timescale 1ns/100ps
module pin_source (
  input wire logic clk,
  output logic capturePin,
  output logic externalClockPin
);
  initial begin
    capturePin = 1'b0;
    externalClockPin = 1'b0;
  end

  // Pin level changed just after an edge, then held
  task automatic capLevel(input logic lvl, input int cycles);
    @(posedge clk);
    capturePin <= lvl;
    repeat (cycles) @(posedge clk);
  endtask

  // Slow pulses so the synchroniser never misses an edge; pin stands still between
  task automatic extPulses(input int n, input logic endHigh);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      externalClockPin <= 1'b1;
      repeat (4) @(posedge clk);
      externalClockPin <= 1'b0;
    end
    repeat (4) @(posedge clk);
    externalClockPin <= endHigh;
    repeat (8) @(posedge clk);
  endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the timer control block
`timescale 1ns/100ps
module testbench;
  import timer_pkg::*;
  logic clk;
  logic rst_b;
  apb_req_t apbReq;
  apb_rsp_t apbRsp;
  logic capturePin;
  logic externalClockPin;
  logic overflowFlag;
  logic captureFlag;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] rdData;
  logic rdErr;
  int lat0;
  int lat1;
  logic [3:0] mode;
  logic [15:0] top;
  logic wrap;
  logic ovf;
  int divs[5] = '{1, 8, 64, 256, 1024};
  // Mode, TOP, wraps past TOP, overflow seen in the run
  localparam logic [21:0] MODE_TAB [15] = '{
    {4'h0, 16'hFFFF, 2'h3}, {4'h1, 16'h00FF, 2'h0}, {4'h2, 16'h01FF, 2'h0},
    {4'h3, 16'h03FF, 2'h0}, {4'h4, 16'h0100, 2'h2}, {4'h5, 16'h00FF, 2'h3},
    {4'h6, 16'h01FF, 2'h3}, {4'h7, 16'h03FF, 2'h3}, {4'h8, 16'h0100, 2'h0},
    {4'h9, 16'h0100, 2'h0}, {4'hA, 16'h0100, 2'h0}, {4'hB, 16'h0100, 2'h0},
    {4'hC, 16'h0100, 2'h2}, {4'hE, 16'h0100, 2'h3}, {4'hF, 16'h0100, 2'h3}};

  timer16_ctrl u_timer16_ctrl (.clk(clk), .rst_b(rst_b), .apbReq(apbReq),
    .apbRsp(apbRsp), .capturePin(capturePin), .externalClockPin(externalClockPin),
    .overflowFlag(overflowFlag), .captureFlag(captureFlag));
  pin_source u_pin_source (.clk(clk), .capturePin(capturePin),
    .externalClockPin(externalClockPin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        n_errors++;
        summarize();
      end
    end while (apbRsp.pready !== 1'b1);
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdData, exp);
  endtask

  task automatic rangeChk(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0);
    check({31'h0, rdData >= lo && rdData <= hi}, 32'h1);
  endtask

  // Edges from the pin change until the capture flag is seen
  task automatic waitCap(output int lat);
    lat = 0;
    while (captureFlag !== 1'b1) begin
      @(posedge clk);
      lat++;
      if (lat > 40) begin
        n_errors++;
        summarize();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    apbReq = '0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rdChk(ADDR_CONTROL_B, 32'h0);
    wr(ADDR_CONTROL_B, 32'hFF);
    rdChk(ADDR_CONTROL_B, 32'hDF);
    apb(1'b0, 12'h3FC, 32'h0);
    check({rdErr, rdData[30:0]}, 32'h80000000);
    wr(ADDR_CONTROL_B, 32'h0);
    wr(ADDR_COUNTER, 32'h1234);
    repeat (20) @(posedge clk);
    rdChk(ADDR_COUNTER, 32'h1234);
    for (int k = 1; k <= 5; k++) begin
      wr(ADDR_COUNTER, 32'h0);
      wr(ADDR_CONTROL_B, k);
      repeat (16 * divs[k - 1]) @(posedge clk);
      wr(ADDR_CONTROL_B, 32'h0);
      rangeChk(ADDR_COUNTER, 32'hF, 32'h13);
    end
    // Reserved mode 13 left out of the table
    for (int i = 0; i < 15; i++) begin
      {mode, top, wrap, ovf} = MODE_TAB[i];
      wr(ADDR_CONTROL_B, 32'h0);
      wr(ADDR_CONTROL_A, 32'h0);
      wr(ADDR_COMPARE_A, 32'h100);
      wr(ADDR_CAPTURE, 32'h100);
      wr(ADDR_CONTROL_A, {30'h0, mode[1:0]});
      // Short run through BOTTOM so a dual-slope count leaves heading up
      wr(ADDR_COUNTER, 32'h2);
      wr(ADDR_CONTROL_B, {27'h0, mode[3:2], 3'h1});
      repeat (10) @(posedge clk);
      wr(ADDR_CONTROL_B, {27'h0, mode[3:2], 3'h0});
      wr(ADDR_COUNTER, {16'h0, top - 16'h8});
      wr(ADDR_STATUS, 32'h3);
      wr(ADDR_CONTROL_B, {27'h0, mode[3:2], 3'h1});
      repeat (20) @(posedge clk);
      wr(ADDR_CONTROL_B, {27'h0, mode[3:2], 3'h0});
      if (wrap) begin
        rangeChk(ADDR_COUNTER, 32'h0, 32'h18);
      end else begin
        rangeChk(ADDR_COUNTER, top - 32'h18, top - 32'h4);
      end
      rdChk(ADDR_STATUS, {31'h0, ovf});
      check({31'h0, overflowFlag}, {31'h0, ovf});
    end
    wr(ADDR_CONTROL_A, 32'h0);
    wr(ADDR_CONTROL_B, 32'h40);
    wr(ADDR_COUNTER, 32'h0ABC);
    wr(ADDR_STATUS, 32'h3);
    u_pin_source.capLevel(1'b1, 0);
    waitCap(lat0);
    rdChk(ADDR_CAPTURE, 32'h0ABC);
    rdChk(ADDR_STATUS, 32'h2);
    wr(ADDR_STATUS, 32'h3);
    u_pin_source.capLevel(1'b0, 10);
    rdChk(ADDR_STATUS, 32'h0);
    wr(ADDR_CONTROL_B, 32'h0);
    wr(ADDR_STATUS, 32'h3);
    u_pin_source.capLevel(1'b1, 10);
    rdChk(ADDR_STATUS, 32'h0);
    wr(ADDR_COUNTER, 32'h0123);
    u_pin_source.capLevel(1'b0, 0);
    waitCap(lat1);
    rdChk(ADDR_CAPTURE, 32'h0123);
    wr(ADDR_CONTROL_B, 32'hC0);
    wr(ADDR_STATUS, 32'h3);
    // Glitch three samples wide: one short of what the filter passes
    u_pin_source.capLevel(1'b1, 2);
    u_pin_source.capLevel(1'b0, 10);
    rdChk(ADDR_STATUS, 32'h0);
    u_pin_source.capLevel(1'b1, 0);
    waitCap(lat1);
    check(lat1 - lat0, 32'h4);
    for (int m = 8; m <= 14; m += 2) begin
      wr(ADDR_CONTROL_B, 32'h0);
      u_pin_source.capLevel(1'b0, 4);
      wr(ADDR_CONTROL_A, m & 3);
      wr(ADDR_CONTROL_B, {24'h0, 2'h1, 1'b0, m[3:2], 3'h0});
      wr(ADDR_STATUS, 32'h3);
      u_pin_source.capLevel(1'b1, 10);
      rdChk(ADDR_STATUS, 32'h0);
    end
    wr(ADDR_CONTROL_A, 32'h0);
    wr(ADDR_CONTROL_B, 32'h0);
    wr(ADDR_COUNTER, 32'h0);
    wr(ADDR_CONTROL_B, 32'h7);
    u_pin_source.extPulses(5, 1'b1);
    rdChk(ADDR_COUNTER, 32'h6);
    wr(ADDR_COUNTER, 32'h0);
    wr(ADDR_CONTROL_B, 32'h6);
    u_pin_source.extPulses(5, 1'b0);
    rdChk(ADDR_COUNTER, 32'h5);
    summarize();
  end
endmodule

// File: src/capture_filter.sv
// Capture pin conditioner: synchroniser, four-sample filter and edge detect
`timescale 1ns/100ps
module capture_filter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pinIn,
  input wire logic filterEn,
  input wire logic edgeRising,
  output logic trigger
);
  import timer_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic [FILTER_SAMPLES-2:0] hist_q;
  logic [FILTER_SAMPLES-1:0] window;
  logic filt_q;
  logic level;
  logic prev_q;

  // Reset to the idle low pin level, so release makes no false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
    end
  end

  // Three stored samples plus the live one, so the delay is exactly four
  assign window = {hist_q, sync2_q};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end else begin
      hist_q <= window[FILTER_SAMPLES-2:0];
      if (&window)
        filt_q <= 1'b1;
      else if (~|window)
        filt_q <= 1'b0;
    end
  end

  assign level = filterEn ? filt_q : sync2_q;

  always_ff @(posedge clk) begin
    if (!rst_b)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  // Zero picks falling, one picks rising
  assign trigger = edgeRising ? (level & ~prev_q) : (~level & prev_q);

  a_filter_needs_four: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(filt_q) |-> $past(window) == {FILTER_SAMPLES{filt_q}})
    else $error("filter output changed without stable samples");

endmodule

// File: src/timer16_ctrl.sv
// 16-bit timer control: mode decode, counting, capture path, clock select, APB registers
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module timer16_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire timer_pkg::apb_req_t apbReq,
  output timer_pkg::apb_rsp_t apbRsp,
  input wire logic capturePin,
  input wire logic externalClockPin,
  output logic overflowFlag,
  output logic captureFlag
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] ctrlA_q;
  logic [7:0] ctrlB_q;
  logic [15:0] count_q;
  logic [15:0] capReg_q;
  logic [15:0] cmpA_q;
  logic [15:0] cmpABuf_q;
  logic downCount_q;
  logic ovf_q;
  logic cap_q;
  logic [3:0] waveformMode;
  mode_decode_t dec;
  logic wrEn;
  logic setupPhase;
  logic [15:0] topVal;
  logic tick;
  logic capTrig;
  logic atTop;
  logic atBottom;
  logic doUpdate;

  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready;
  assign waveformMode = {ctrlB_q[MODE_HI_MSB:MODE_HI_LSB], ctrlA_q[1:0]};

  always_comb begin
    dec = '{SCHEME_NORMAL, TOPSRC_FIXED, TOP_MAX, POINT_IMMEDIATE, POINT_MAX};
    case (waveformMode)
      4'h0: dec = '{SCHEME_NORMAL, TOPSRC_FIXED, TOP_MAX, POINT_IMMEDIATE, POINT_MAX};
      4'h1: dec = '{SCHEME_DUAL, TOPSRC_FIXED, TOP_8BIT, POINT_TOP, POINT_BOTTOM};
      4'h2: dec = '{SCHEME_DUAL, TOPSRC_FIXED, TOP_9BIT, POINT_TOP, POINT_BOTTOM};
      4'h3: dec = '{SCHEME_DUAL, TOPSRC_FIXED, TOP_10BIT, POINT_TOP, POINT_BOTTOM};
      4'h4: dec = '{SCHEME_CLEAR, TOPSRC_COMPARE, TOP_MAX, POINT_IMMEDIATE, POINT_MAX};
      4'h5: dec = '{SCHEME_FAST, TOPSRC_FIXED, TOP_8BIT, POINT_BOTTOM, POINT_TOP};
      4'h6: dec = '{SCHEME_FAST, TOPSRC_FIXED, TOP_9BIT, POINT_BOTTOM, POINT_TOP};
      4'h7: dec = '{SCHEME_FAST, TOPSRC_FIXED, TOP_10BIT, POINT_BOTTOM, POINT_TOP};
      4'h8: dec = '{SCHEME_DUAL, TOPSRC_CAPTURE, TOP_MAX, POINT_BOTTOM, POINT_BOTTOM};
      4'h9: dec = '{SCHEME_DUAL, TOPSRC_COMPARE, TOP_MAX, POINT_BOTTOM, POINT_BOTTOM};
      4'hA: dec = '{SCHEME_DUAL, TOPSRC_CAPTURE, TOP_MAX, POINT_TOP, POINT_BOTTOM};
      4'hB: dec = '{SCHEME_DUAL, TOPSRC_COMPARE, TOP_MAX, POINT_TOP, POINT_BOTTOM};
      4'hC: dec = '{SCHEME_CLEAR, TOPSRC_CAPTURE, TOP_MAX, POINT_IMMEDIATE, POINT_MAX};
      4'hE: dec = '{SCHEME_FAST, TOPSRC_CAPTURE, TOP_MAX, POINT_BOTTOM, POINT_TOP};
      4'hF: dec = '{SCHEME_FAST, TOPSRC_COMPARE, TOP_MAX, POINT_BOTTOM, POINT_TOP};
      // Reserved encoding behaves as normal count so the counter stays bounded
      default: dec = '{SCHEME_NORMAL, TOPSRC_FIXED, TOP_MAX, POINT_IMMEDIATE, POINT_MAX};
    endcase
  end

  always_comb begin
    case (dec.topSrc)
      TOPSRC_CAPTURE: topVal = capReg_q;
      TOPSRC_COMPARE: topVal = cmpA_q;
      default: topVal = dec.fixedTop;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock select and prescaler
  // ----------------------------------------------------------------
  logic [9:0] pre_q;
  logic ext1_q;
  logic ext2_q;
  logic extPrev_q;
  logic extRise;
  logic extFall;

  always_ff @(posedge clk) begin
    if (!rst_b)
      pre_q <= 10'h000;
    else
      pre_q <= pre_q + 10'h001;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      ext1_q <= externalClockPin;
      ext2_q <= ext1_q;
      extPrev_q <= ext2_q;
    end
  end

  assign extRise = ext2_q & ~extPrev_q;
  assign extFall = ~ext2_q & extPrev_q;

  always_comb begin
    case (ctrlB_q[CLKSEL_MSB:0])
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_q & DIV8_MASK) == DIV8_MASK;
      3'h3: tick = (pre_q & DIV64_MASK) == DIV64_MASK;
      3'h4: tick = (pre_q & DIV256_MASK) == DIV256_MASK;
      3'h5: tick = pre_q == DIV1024_MASK;
      3'h6: tick = extFall;
      3'h7: tick = extRise;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter, compare double buffer, flags
  // ----------------------------------------------------------------
  assign atTop = count_q == topVal;
  assign atBottom = count_q == BOTTOM;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= COUNT_RESET;
      downCount_q <= 1'b0;
    end else if (wrEn && apbReq.paddr == ADDR_COUNTER) begin
      count_q <= apbReq.pwdata[15:0];
    end else if (tick) begin
      case (dec.scheme)
        SCHEME_CLEAR, SCHEME_FAST: count_q <= atTop ? BOTTOM : count_q + 16'h0001;
        SCHEME_DUAL: begin
          if (atTop && !downCount_q) begin
            downCount_q <= 1'b1;
            count_q <= count_q - 16'h0001;
          end else if (atBottom && downCount_q) begin
            downCount_q <= 1'b0;
            count_q <= count_q + 16'h0001;
          end else if (downCount_q) begin
            count_q <= count_q - 16'h0001;
          end else begin
            count_q <= count_q + 16'h0001;
          end
        end
        default: count_q <= count_q + 16'h0001;
      endcase
    end
  end

  always_comb begin
    case (dec.updateAt)
      POINT_TOP: doUpdate = tick & atTop;
      POINT_BOTTOM: doUpdate = tick & atBottom;
      default: doUpdate = 1'b1;
    endcase
  end

  // Buffered compare value; immediate modes copy every cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmpABuf_q <= COUNT_RESET;
      cmpA_q <= COUNT_RESET;
    end else begin
      if (wrEn && apbReq.paddr == ADDR_COMPARE_A)
        cmpABuf_q <= apbReq.pwdata[15:0];
      if (doUpdate)
        cmpA_q <= cmpABuf_q;
    end
  end

  logic ovfEvent;
  always_comb begin
    case (dec.overflowAt)
      POINT_TOP: ovfEvent = tick & atTop;
      POINT_BOTTOM: ovfEvent = tick & atBottom & downCount_q;
      POINT_MAX: ovfEvent = tick & (count_q == TOP_MAX);
      default: ovfEvent = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Capture path
  // ----------------------------------------------------------------
  logic capRaw;
  capture_filter u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn(capturePin),
    .filterEn(ctrlB_q[FILTER_BIT]),
    .edgeRising(ctrlB_q[EDGE_BIT]),
    .trigger(capRaw)
  );

  assign capTrig = capRaw & (dec.topSrc != TOPSRC_CAPTURE);

  always_ff @(posedge clk) begin
    if (!rst_b)
      capReg_q <= COUNT_RESET;
    else if (capTrig)
      capReg_q <= count_q;
    else if (wrEn && apbReq.paddr == ADDR_CAPTURE)
      capReg_q <= apbReq.pwdata[15:0];
  end

  // Write-one-to-clear; a same-cycle event wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ovf_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      if (ovfEvent)
        ovf_q <= 1'b1;
      else if (wrEn && apbReq.paddr == ADDR_STATUS && apbReq.pwdata[STAT_OVF_BIT])
        ovf_q <= 1'b0;
      if (capTrig)
        cap_q <= 1'b1;
      else if (wrEn && apbReq.paddr == ADDR_STATUS && apbReq.pwdata[STAT_CAP_BIT])
        cap_q <= 1'b0;
    end
  end

  assign overflowFlag = ovf_q;
  assign captureFlag = cap_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrlA_q <= CONTROL_RESET;
      ctrlB_q <= CONTROL_RESET;
    end else if (wrEn) begin
      if (apbReq.paddr == ADDR_CONTROL_A)
        ctrlA_q <= apbReq.pwdata[7:0];
      if (apbReq.paddr == ADDR_CONTROL_B)
        ctrlB_q <= apbReq.pwdata[7:0] & CONTROL_B_MASK;
    end
  end

  logic [31:0] rdata;
  logic mapped;
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (apbReq.paddr)
      ADDR_CONTROL_A: rdata = {24'h000000, ctrlA_q};
      ADDR_CONTROL_B: rdata = {24'h000000, ctrlB_q};
      ADDR_COUNTER: rdata = {16'h0000, count_q};
      ADDR_CAPTURE: rdata = {16'h0000, capReg_q};
      ADDR_COMPARE_A: rdata = {16'h0000, cmpABuf_q};
      ADDR_STATUS: rdata = {30'h0, cap_q, ovf_q};
      default: mapped = 1'b0;
    endcase
  end

  // Answer registered in setup: no wait state, but read data is one cycle old
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= setupPhase;
      apbRsp.pslverr <= setupPhase & ~mapped;
      apbRsp.prdata <= (setupPhase & ~apbReq.pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stop_no_count: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrlB_q[CLKSEL_MSB:0] == 3'h0 && !wrEn) |=> $stable(count_q))
    else $error("counter moved with clock removed");
  a_bit5_zero: assert property (@(posedge clk) disable iff (!rst_b)
    ctrlB_q[5] == 1'b0)
    else $error("control B bit 5 set");
  a_capture_copies: assert property (@(posedge clk) disable iff (!rst_b)
    capTrig |=> cap_q && capReg_q == $past(count_q))
    else $error("capture did not copy counter");
  a_capture_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    (dec.topSrc == TOPSRC_CAPTURE && !wrEn) |=> $stable(capReg_q) && !$rose(cap_q))
    else $error("capture while capture register is TOP");
  a_fast_wraps: assert property (@(posedge clk) disable iff (!rst_b)
    (dec.scheme == SCHEME_FAST && tick && atTop && !wrEn) |=> count_q == BOTTOM)
    else $error("fast mode did not wrap at TOP");
  a_dual_turns: assert property (@(posedge clk) disable iff (!rst_b)
    (dec.scheme == SCHEME_DUAL && tick && atTop && !downCount_q && !atBottom && !wrEn)
      |=> downCount_q)
    else $error("dual slope did not turn at TOP");
  a_dual_ovf: assert property (@(posedge clk) disable iff (!rst_b)
    (dec.overflowAt == POINT_BOTTOM && tick && atBottom && downCount_q) |=> ovf_q)
    else $error("overflow flag missing at BOTTOM");
  a_load_at_top: assert property (@(posedge clk) disable iff (!rst_b)
    (dec.updateAt == POINT_TOP && !(tick && atTop)) |=> cmpA_q == $past(cmpA_q))
    else $error("compare A loaded away from TOP");
  a_max_ovf: assert property (@(posedge clk) disable iff (!rst_b)
    (waveformMode == 4'h0 && tick && count_q == TOP_MAX) |=> ovf_q)
    else $error("overflow flag missing at MAX");
  a_div1_ticks: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrlB_q[CLKSEL_MSB:0] == 3'h1 && dec.scheme == SCHEME_NORMAL && !wrEn)
      |=> count_q == $past(count_q) + 16'h0001)
    else $error("undivided clock missed a tick");

endmodule

// File: src/timer_pkg.sv
// Package with register map, field layout and mode decode constants for the timer control block
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets not multiples of four: index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_A = 8'h80;
  localparam logic [7:0] IDX_CONTROL_B = 8'h81;
  localparam logic [7:0] IDX_COUNTER = 8'h84;
  localparam logic [7:0] IDX_CAPTURE = 8'h86;
  localparam logic [7:0] IDX_COMPARE_A = 8'h88;
  localparam logic [7:0] IDX_STATUS = 8'h8C;
  localparam logic [11:0] ADDR_CONTROL_A = {2'h0, IDX_CONTROL_A, 2'h0};
  localparam logic [11:0] ADDR_CONTROL_B = {2'h0, IDX_CONTROL_B, 2'h0};
  localparam logic [11:0] ADDR_COUNTER = {2'h0, IDX_COUNTER, 2'h0};
  localparam logic [11:0] ADDR_CAPTURE = {2'h0, IDX_CAPTURE, 2'h0};
  localparam logic [11:0] ADDR_COMPARE_A = {2'h0, IDX_COMPARE_A, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FILTER_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam int MODE_HI_MSB = 4;
  localparam int MODE_HI_LSB = 3;
  localparam int CLKSEL_MSB = 2;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CAP_BIT = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_MASK = 8'hDF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int FILTER_SAMPLES = 4;

  // ----------------------------------------------------------------
  // Fixed TOP values and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  typedef enum logic [1:0] {
    SCHEME_NORMAL = 2'b00,
    SCHEME_CLEAR = 2'b01,
    SCHEME_FAST = 2'b10,
    SCHEME_DUAL = 2'b11
  } scheme_t;

  typedef enum logic [1:0] {
    TOPSRC_FIXED = 2'b00,
    TOPSRC_CAPTURE = 2'b01,
    TOPSRC_COMPARE = 2'b10
  } top_src_t;

  typedef enum logic [1:0] {
    POINT_IMMEDIATE = 2'b00,
    POINT_TOP = 2'b01,
    POINT_BOTTOM = 2'b10,
    POINT_MAX = 2'b11
  } point_t;

  typedef struct packed {
    scheme_t scheme;
    top_src_t topSrc;
    logic [15:0] fixedTop;
    point_t updateAt;
    point_t overflowAt;
  } mode_decode_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage
